/* rtl/rlsw_map.svh */
`ifndef RLSW_MAP_SVH
`define RLSW_MAP_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define RLSW_CLK_HZ 32'h0BEB_C200
`define RLSW_MS_PER_S 32'h0000_03E8
`define RLSW_PAUSE_MS 8'h64
`define RLSW_MAX_STEPS 24'hFF_FFFF

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RLSW_CTRL_OFS 8'h00
`define RLSW_CFG_OFS 8'h04
`define RLSW_MIN_OFS 8'h08
`define RLSW_MAX_OFS 8'h0C
`define RLSW_RAMP_OFS 8'h10
`define RLSW_STAT_OFS 8'h14
`define RLSW_POS_OFS 8'h18
`define RLSW_PROF_SEL 2'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define RLSW_CTRL_MODE_LSB 0
`define RLSW_CTRL_START_BIT 2
`define RLSW_CFG_NC_BIT 0
`define RLSW_CFG_REF_LSB 1
`define RLSW_CFG_NRM_LSB 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define RLSW_MIN_RST 24'h00_0190
`define RLSW_MAX_RST 24'h00_03E8
`define RLSW_RAMP_RST 16'h000A
`define RLSW_ANA_SCALE 14'h0040

`endif

/* rtl/rlsw_pkg.sv */
package rlsw_pkg;

	typedef enum logic [2:0] {
		RLSW_IDLE = 3'h0,
		RLSW_RUN = 3'h1,
		RLSW_PAUSE = 3'h3,
		RLSW_LEAVE = 3'h2
	} rlsw_state_t;

	typedef enum logic [1:0] {
		RLSW_M_POS = 2'h0,
		RLSW_M_ANA = 2'h1,
		RLSW_M_EXTREF = 2'h2,
		RLSW_M_INTREF = 2'h3
	} rlsw_mode_t;

	typedef enum logic [1:0] {
		RLSW_FREE_BACK = 2'h0,
		RLSW_FREE_FWD = 2'h1,
		RLSW_STOP = 2'h2,
		RLSW_DISABLE = 2'h3
	} rlsw_react_t;

endpackage : rlsw_pkg

/* rtl/rlsw_step_gen.sv */
`timescale 1ns/10ps
`include "rlsw_map.svh"

module rlsw_step_gen #(
	parameter int FW = 24
) (
	input wire logic clock, // system clock
	input wire logic sys_rst, // async reset
	input wire logic ce, // clock enable
	input wire logic run, // step generation allowed
	input wire logic [FW-1:0] freq, // step rate in Hz
	output logic step // one-cycle step pulse
);
	logic [31:0] acc_reg;
	logic [31:0] sum;
	logic wrap;

	// phase accumulator: one wrap per step, so rate is exact on average
	assign sum = acc_reg + 32'(freq);
	assign wrap = sum >= `RLSW_CLK_HZ;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			acc_reg <= 32'h0000_0000;
			step <= 1'b0;
		end else if (ce) begin
			step <= run & wrap;
			if (!run)
				acc_reg <= 32'h0000_0000;
			else if (wrap)
				acc_reg <= sum - `RLSW_CLK_HZ;
			else
				acc_reg <= sum;
		end
	end
endmodule : rlsw_step_gen

/* rtl/rlsw_top.sv */
`timescale 1ns/10ps
`include "rlsw_map.svh"

module rlsw_top #(
	parameter int MS_CYCLES = `RLSW_CLK_HZ / `RLSW_MS_PER_S,
	parameter logic [13:0] ANA_SCALE = `RLSW_ANA_SCALE,
	parameter int NPROF = 16
) (
	input wire logic clock, // 200 MHz system clock
	input wire logic sys_rst, // async reset, high
	input wire logic ce, // clock enable, freezes all state
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write
	input wire logic [2:0] hsize, // ahb size, words only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb ready in
	output logic hreadyout, // ahb ready out
	output logic hresp, // ahb response
	output logic [31:0] hrdata, // ahb read data
	input wire logic start_in, // start pin
	input wire logic [3:0] sel_in, // profile select pins
	input wire logic dir_in, // direction pin
	input wire logic ref_sw_in, // external reference/limit switch
	input wire logic shaft_ref_in, // shaft reference mark
	input wire logic [9:0] ana_in, // analogue sample
	output logic step_out, // step pulse
	output logic dir_out, // motor direction
	output logic out1, // digital output one
	output logic out2 // digital output two
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [23:0] rlsw_up(input logic [23:0] f, input logic [15:0] r,
		input logic [23:0] lim);
		logic [24:0] s;
		s = {1'b0, f} + {9'h000, r};
		rlsw_up = (s >= {1'b0, lim}) ? lim : s[23:0];
	endfunction : rlsw_up

	function automatic logic [23:0] rlsw_dn(input logic [23:0] f, input logic [15:0] r,
		input logic [23:0] lim);
		logic [24:0] s;
		s = {1'b0, f} - {9'h000, r};
		rlsw_dn = (s[24] || s[23:0] <= lim) ? lim : s[23:0];
	endfunction : rlsw_dn

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic start_s1, start_s2, dir_s1, dir_s2, sw_s1, sw_s2, shaft_s1, shaft_s2;
	logic [3:0] sel_s1, sel_s2;
	logic [9:0] ana_s1, ana_s2;
	logic start_d_reg;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			{start_s1, start_s2, dir_s1, dir_s2} <= 4'h0;
			{sw_s1, sw_s2, shaft_s1, shaft_s2} <= 4'h0;
			{sel_s1, sel_s2} <= 8'h00;
			{ana_s1, ana_s2} <= 20'h0_0000;
			start_d_reg <= 1'b0;
		end else if (ce) begin
			{start_s1, dir_s1, sw_s1, shaft_s1} <= {start_in, dir_in, ref_sw_in, shaft_ref_in};
			{start_s2, dir_s2, sw_s2, shaft_s2} <= {start_s1, dir_s1, sw_s1, shaft_s1};
			sel_s1 <= sel_in;
			sel_s2 <= sel_s1;
			ana_s1 <= ana_in;
			ana_s2 <= ana_s1;
			start_d_reg <= start_s2;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	rlsw_pkg::rlsw_state_t state_reg;
	rlsw_pkg::rlsw_mode_t mode_reg;
	rlsw_pkg::rlsw_react_t ref_react_reg, nrm_react_reg;
	logic nc_reg;
	logic [23:0] min_reg, max_reg;
	logic [15:0] ramp_reg;
	logic [23:0] prof_reg [NPROF];
	logic wr_reg;
	logic [7:0] wa_reg;
	logic [31:0] hrdata_reg;
	logic [23:0] pos_reg, rem_reg, accn_reg, freq_reg;
	logic dir_reg, refd_reg, lost_reg;
	logic [31:0] ms_cnt_reg;
	logic [7:0] pause_reg;

	// ----------------------------------------
	// ahb-lite slave, zero wait states
	// ----------------------------------------
	logic take, wr_any;
	logic [7:0] ra;
	logic [31:0] rd_word;
	logic wr_ctrl, wr_cfg, wr_prof;
	logic [3:0] wr_pidx;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign take = hsel & hready & htrans[1];
	assign ra = haddr[7:0];
	assign wr_any = wr_reg & hready;
	assign wr_ctrl = wr_any && wa_reg == `RLSW_CTRL_OFS;
	assign wr_cfg = wr_any && wa_reg == `RLSW_CFG_OFS;
	assign wr_prof = wr_any && wa_reg[7:6] == `RLSW_PROF_SEL;
	assign wr_pidx = wa_reg[5:2];
	// read data is taken in the address phase, so a read right after a
	// write to the same word returns the old value
	assign rd_word =
		(ra == `RLSW_CTRL_OFS) ? {30'h0000_0000, mode_reg} :
		(ra == `RLSW_CFG_OFS) ? {27'h000_0000, nrm_react_reg, ref_react_reg, nc_reg} :
		(ra == `RLSW_MIN_OFS) ? {8'h00, min_reg} :
		(ra == `RLSW_MAX_OFS) ? {8'h00, max_reg} :
		(ra == `RLSW_RAMP_OFS) ? {16'h0000, ramp_reg} :
		(ra == `RLSW_STAT_OFS) ? {26'h000_0000, state_reg, lost_reg, refd_reg,
			state_reg != rlsw_pkg::RLSW_IDLE} :
		(ra == `RLSW_POS_OFS) ? {8'h00, pos_reg} :
		(ra[7:6] == `RLSW_PROF_SEL) ? {8'h00, prof_reg[ra[5:2]]} :
		32'h0000_0000;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_reg <= 1'b0;
			wa_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else if (ce && hready) begin
			wr_reg <= take & hwrite;
			wa_reg <= ra;
			if (take && !hwrite)
				hrdata_reg <= rd_word;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg <= rlsw_pkg::RLSW_M_POS;
			nc_reg <= 1'b0;
			ref_react_reg <= rlsw_pkg::RLSW_FREE_BACK;
			nrm_react_reg <= rlsw_pkg::RLSW_DISABLE;
			min_reg <= `RLSW_MIN_RST;
			max_reg <= `RLSW_MAX_RST;
			ramp_reg <= `RLSW_RAMP_RST;
		end else if (ce && wr_any) begin
			if (wr_ctrl)
				mode_reg <= rlsw_pkg::rlsw_mode_t'(hwdata[`RLSW_CTRL_MODE_LSB +: 2]);
			if (wr_cfg) begin
				nc_reg <= hwdata[`RLSW_CFG_NC_BIT];
				ref_react_reg <= rlsw_pkg::rlsw_react_t'(hwdata[`RLSW_CFG_REF_LSB +: 2]);
				nrm_react_reg <= rlsw_pkg::rlsw_react_t'(hwdata[`RLSW_CFG_NRM_LSB +: 2]);
			end
			if (wa_reg == `RLSW_MIN_OFS)
				min_reg <= hwdata[23:0];
			if (wa_reg == `RLSW_MAX_OFS)
				max_reg <= hwdata[23:0];
			if (wa_reg == `RLSW_RAMP_OFS)
				ramp_reg <= hwdata[15:0];
		end
	end

	// profile table has no reset: software loads it before use
	always_ff @(posedge clock) begin
		if (ce && wr_prof)
			prof_reg[wr_pidx] <= hwdata[23:0];
	end

	// ----------------------------------------
	// motion decode
	// ----------------------------------------
	logic go, sw_act, ref_run, hit, tick, step, dec, running, leave_dir;
	logic [23:0] ana_pos, ana_dist;
	logic ana_fwd;
	rlsw_pkg::rlsw_mode_t run_mode;

	assign go = (start_s2 & ~start_d_reg) | (wr_ctrl & hwdata[`RLSW_CTRL_START_BIT]);
	// a start written together with a new mode must run that mode, not the old one
	assign run_mode = wr_ctrl ? rlsw_pkg::rlsw_mode_t'(hwdata[`RLSW_CTRL_MODE_LSB +: 2]) : mode_reg;
	assign sw_act = sw_s2 ^ nc_reg;
	assign ref_run = mode_reg == rlsw_pkg::RLSW_M_EXTREF || mode_reg == rlsw_pkg::RLSW_M_INTREF;
	assign hit = (mode_reg == rlsw_pkg::RLSW_M_INTREF) ? shaft_s2 : sw_act;
	assign tick = ms_cnt_reg == 32'(MS_CYCLES - 1);
	assign ana_pos = 24'({14'h0000, ana_s2} * {10'h000, ANA_SCALE});
	assign ana_fwd = ana_pos >= pos_reg;
	assign ana_dist = ana_fwd ? ana_pos - pos_reg : pos_reg - ana_pos;
	// decelerate once the steps left equal the steps spent accelerating
	assign dec = !ref_run && rem_reg <= accn_reg;
	assign running = state_reg == rlsw_pkg::RLSW_RUN || state_reg == rlsw_pkg::RLSW_LEAVE;
	assign leave_dir = (ref_react_reg == rlsw_pkg::RLSW_FREE_FWD) ? dir_reg : ~dir_reg;
	assign dir_out = dir_reg;
	assign out1 = refd_reg;
	assign out2 = refd_reg;

	rlsw_step_gen #(
		.FW(24)
	) u_step (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.run(running),
		.freq(freq_reg),
		.step(step)
	);
	assign step_out = step;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			ms_cnt_reg <= 32'h0000_0000;
		else if (ce)
			ms_cnt_reg <= tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= rlsw_pkg::RLSW_IDLE;
			rem_reg <= 24'h00_0000;
			accn_reg <= 24'h00_0000;
			freq_reg <= `RLSW_MIN_RST;
			dir_reg <= 1'b0;
			refd_reg <= 1'b0;
			lost_reg <= 1'b0;
			pause_reg <= 8'h00;
		end else if (ce) begin
			if (step && state_reg == rlsw_pkg::RLSW_RUN) begin
				rem_reg <= rem_reg - 24'h00_0001;
				if (!dec && freq_reg < max_reg)
					accn_reg <= accn_reg + 24'h00_0001;
			end
			case (state_reg)
				rlsw_pkg::RLSW_IDLE: begin
					freq_reg <= min_reg;
					if (go) begin
						refd_reg <= 1'b0;
						accn_reg <= 24'h00_0000;
						state_reg <= rlsw_pkg::RLSW_RUN;
						case (run_mode)
							rlsw_pkg::RLSW_M_POS: begin
								rem_reg <= prof_reg[sel_s2];
								dir_reg <= dir_s2;
							end
							rlsw_pkg::RLSW_M_ANA: begin
								rem_reg <= ana_dist;
								dir_reg <= ana_fwd;
							end
							default: begin
								rem_reg <= `RLSW_MAX_STEPS;
								dir_reg <= dir_s2;
							end
						endcase
					end
				end
				rlsw_pkg::RLSW_RUN: begin
					if (ref_run && hit) begin
						refd_reg <= 1'b1;
						freq_reg <= min_reg;
						pause_reg <= 8'h00;
						if (mode_reg == rlsw_pkg::RLSW_M_EXTREF) begin
							state_reg <= rlsw_pkg::RLSW_PAUSE;
						end else begin
							dir_reg <= leave_dir;
							state_reg <= rlsw_pkg::RLSW_LEAVE;
						end
					end else if (!ref_run && sw_act &&
						nrm_react_reg != rlsw_pkg::RLSW_DISABLE) begin
						refd_reg <= 1'b1;
						freq_reg <= min_reg;
						case (nrm_react_reg)
							rlsw_pkg::RLSW_STOP: begin
								lost_reg <= 1'b1;
								state_reg <= rlsw_pkg::RLSW_IDLE;
							end
							rlsw_pkg::RLSW_FREE_BACK: begin
								dir_reg <= ~dir_reg;
								state_reg <= rlsw_pkg::RLSW_LEAVE;
							end
							default: begin
								state_reg <= rlsw_pkg::RLSW_LEAVE;
							end
						endcase
					end else if (!ref_run && rem_reg == 24'h00_0000) begin
						state_reg <= rlsw_pkg::RLSW_IDLE;
					end else if (tick) begin
						if (mode_reg == rlsw_pkg::RLSW_M_INTREF)
							freq_reg <= min_reg;
						else if (dec)
							freq_reg <= rlsw_dn(freq_reg, ramp_reg, min_reg);
						else
							freq_reg <= rlsw_up(freq_reg, ramp_reg, max_reg);
					end
				end
				rlsw_pkg::RLSW_PAUSE: begin
					if (tick) begin
						pause_reg <= pause_reg + 8'h01;
						if (pause_reg == `RLSW_PAUSE_MS - 8'h01) begin
							dir_reg <= leave_dir;
							state_reg <= rlsw_pkg::RLSW_LEAVE;
						end
					end
				end
				rlsw_pkg::RLSW_LEAVE: begin
					freq_reg <= min_reg;
					if (!hit) begin
						if (ref_run)
							lost_reg <= 1'b0;
						state_reg <= rlsw_pkg::RLSW_IDLE;
					end
				end
				default: state_reg <= rlsw_pkg::RLSW_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// position counter
	// ----------------------------------------
	logic zero_pos;
	// the reference point becomes position zero when the switch, or the shaft mark in internal reference mode, is met
	assign zero_pos = state_reg == rlsw_pkg::RLSW_RUN && ref_run && hit;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			pos_reg <= 24'h00_0000;
		else if (ce) begin
			if (zero_pos)
				pos_reg <= 24'h00_0000;
			else if (step)
				pos_reg <= dir_reg ? pos_reg + 24'h00_0001 : pos_reg - 24'h00_0001;
		end
	end
endmodule : rlsw_top

/* dv/rlsw_asserts.sv */
`timescale 1ns/10ps
`include "rlsw_map.svh"

module rlsw_asserts (
	input wire logic clock, // system clock
	input wire logic sys_rst, // async reset
	input wire logic ce, // clock enable
	input wire logic hsel, // bus select
	input wire logic [31:0] haddr, // bus address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write flag
	input wire logic hready, // bus ready
	input wire logic [31:0] hrdata, // read data
	input wire logic step_out, // step pulse
	input wire logic out1, // output one
	input wire logic out2 // output two
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	wire logic rd_go = hsel && hready && htrans[1] && !hwrite && ce;
	wire logic [7:0] ofs = haddr[7:0];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_outs_paired: assert property (out1 == out2)
		else $error("outputs one and two differ");
	// 24-bit rates can never step faster than one pulse in eleven cycles
	a_step_gap: assert property (step_out |=> !step_out [*8])
		else $error("step pulses too close");
	a_ref_quiet: assert property ($rose(out1) |-> !step_out [*3])
		else $error("step while reference reached");
	a_rdata_hold: assert property (!rd_go |=> $stable(hrdata))
		else $error("read data moved without a read");
	a_pos_width: assert property (rd_go && ofs == `RLSW_POS_OFS |=> hrdata[31:24] == 8'h00)
		else $error("position wider than 24 bits");
	a_dist_width: assert property (rd_go && ofs >= 8'h40 && ofs <= 8'h7C
		|=> hrdata[31:24] == 8'h00)
		else $error("distance wider than 24 bits");
	a_start_pulse: assert property (rd_go && ofs == `RLSW_CTRL_OFS
		|=> hrdata[31:2] == 30'h0000_0000)
		else $error("start bit reads back");
	a_cfg_width: assert property (rd_go && ofs == `RLSW_CFG_OFS
		|=> hrdata[31:5] == 27'h000_0000)
		else $error("config has stray bits");

	c_step: cover property (step_out);
	c_ref_hit: cover property ($rose(out1));
	c_reads: cover property (rd_go ##1 rd_go);
endmodule : rlsw_asserts

bind rlsw_top rlsw_asserts i_chk (.clock(clock), .sys_rst(sys_rst), .ce(ce), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.step_out(step_out), .out1(out1), .out2(out2));

/* dv/rlsw_motor_model.sv */
`timescale 1ns/10ps

module rlsw_motor_model #(
	parameter int REV = 16 // steps per shaft revolution
) (
	input wire logic clock, // system clock
	input wire logic sys_rst, // async reset
	input wire logic step_out, // step pulse
	input wire logic dir_out, // direction, high counts up
	input wire logic nc, // switch wired normally closed
	input wire logic signed [31:0] sw_at, // first position on the switch
	output logic ref_sw_in, // switch level
	output logic shaft_ref_in, // shaft mark
	output logic signed [31:0] pos // shaft position in steps
);
	// switch cam is four steps long, so both leaving directions are seen
	wire logic hit = pos >= sw_at && pos <= sw_at + 3;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pos <= '0;
		end else if (step_out) begin
			pos <= dir_out ? pos + 1 : pos - 1;
		end
	end

	// a closed contact reads high at rest, so a press shows as low
	assign ref_sw_in = hit ^ nc;
	assign shaft_ref_in = (pos % REV) == 0;
endmodule : rlsw_motor_model

/* dv/rlsw_bench.sv */
`timescale 1ns/10ps
`include "rlsw_map.svh"

module rlsw_bench;
	localparam int MS = 100;
	logic clock, sys_rst, ce, hsel, hwrite, start_in, dir_in, nc, out1_d;
	logic [1:0] htrans;
	logic [3:0] sel_in;
	logic [9:0] ana_in;
	logic [31:0] haddr, hwdata, rd;
	logic signed [31:0] sw_at, p0;
	wire logic hreadyout, hresp, ref_sw_in, shaft_ref_in, step_out, dir_out, out1, out2;
	wire logic [31:0] hrdata;
	wire logic signed [31:0] pos;
	int miscompares, n_tests, cyc, gap, gap_min, t_hit, pause, i;

	rlsw_top #(.MS_CYCLES(MS), .ANA_SCALE(14'h0004)) i_dut (
		.clock(clock), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.start_in(start_in), .sel_in(sel_in), .dir_in(dir_in), .ref_sw_in(ref_sw_in),
		.shaft_ref_in(shaft_ref_in), .ana_in(ana_in), .step_out(step_out),
		.dir_out(dir_out), .out1(out1), .out2(out2));
	rlsw_motor_model i_motor (.clock(clock), .sys_rst(sys_rst), .step_out(step_out),
		.dir_out(dir_out), .nc(nc), .sw_at(sw_at), .ref_sw_in(ref_sw_in),
		.shaft_ref_in(shaft_ref_in), .pos(pos));

	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end

	// ----------------------------------------
	// step timing monitor and run limit
	// ----------------------------------------
	always @(posedge clock) begin
		cyc++;
		gap++;
		if (out1 === 1'b1 && out1_d !== 1'b1) begin
			t_hit = cyc;
			pause = -1;
		end
		out1_d = out1;
		if (step_out === 1'b1) begin
			if (pause < 0)
				pause = cyc - t_hit;
			if (gap < gap_min)
				gap_min = gap;
			gap = 0;
		end
		if (cyc == 90000) begin
			miscompares++;
			end_of_test();
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : check

	task ahb_write(input logic [31:0] a, input logic [31:0] d);
		hsel <= 1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= 1;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
	endtask : ahb_write

	task ahb_read(input logic [31:0] a, output logic [31:0] d);
		hsel <= 1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= 0;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hsel <= 0;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		d = hrdata;
	endtask : ahb_read

	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		ahb_read(a, rd);
		check(rd, exp, "register");
	endtask : rd_chk

	// start pin pulse, then poll busy until the run is over
	task run(input logic [3:0] s, input logic d);
		sel_in <= s;
		dir_in <= d;
		repeat (3) @(posedge clock);
		start_in <= 1;
		repeat (4) @(posedge clock);
		start_in <= 0;
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0) ahb_read(`RLSW_STAT_OFS, rd);
	endtask : run

	task end_of_test;
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	initial begin
		{ce, sys_rst, hsel, hwrite, start_in, dir_in, nc, out1_d} = 8'hC1;
		{htrans, sel_in, ana_in, haddr, hwdata} = '0;
		sw_at = 100000;
		{miscompares, n_tests, cyc, gap, t_hit, pause} = '0;
		gap_min = 1000000;
		repeat (3) @(posedge clock);
		sys_rst <= 0;
		rd_chk(`RLSW_MIN_OFS, 32'h0000_0190);
		rd_chk(`RLSW_MAX_OFS, 32'h0000_03E8);
		rd_chk(`RLSW_RAMP_OFS, 32'h0000_000A);
		rd_chk(`RLSW_CFG_OFS, 32'h0000_0018);
		rd_chk(32'h0000_0020, 32'h0000_0000);
		ahb_write(32'h0000_007C, 32'hFFFF_FFFF);
		rd_chk(32'h0000_007C, 32'h00FF_FFFF);
		// a write while the clock enable is low must leave no trace
		ce <= 0;
		ahb_write(`RLSW_MIN_OFS, 32'h0000_0001);
		ce <= 1;
		rd_chk(`RLSW_MIN_OFS, 32'h0000_0190);
		check({31'h0, hresp}, 32'h0000_0000, "response");
		$display("test registers done");
		// fast rates keep each step near a hundred cycles
		ahb_write(`RLSW_MIN_OFS, 32'h001E_8480);
		ahb_write(`RLSW_MAX_OFS, 32'h0020_0B20);
		ahb_write(`RLSW_RAMP_OFS, 32'h0000_FFFF);
		for (i = 0; i < 16; i++) ahb_write(32'h0000_0040 + 32'(4 * i), 32'(i + 4));
		for (i = 0; i < 2; i++) begin
			p0 = pos;
			run(4'(5 + 5 * i), i == 0);
			check(pos - p0, i ? 32'hFFFF_FFF2 : 32'h0000_0009, "travel");
			rd_chk(`RLSW_POS_OFS, {8'h00, pos[23:0]});
		end
		check(32'(gap_min >= 95), 32'h0000_0001, "rate cap");
		$display("test profiles done");
		sw_at <= 0;
		ahb_write(`RLSW_CTRL_OFS, 32'h0000_0002);
		run(4'h0, 1);
		check({31'h0, out1 & out2}, 32'h0000_0001, "ref outs");
		check(pos, 32'hFFFF_FFFF, "free back");
		check(32'(pause >= 99 * MS && pause <= 102 * MS), 32'h0000_0001, "pause");
		rd_chk(`RLSW_POS_OFS, 32'h00FF_FFFF);
		ahb_write(`RLSW_CFG_OFS, 32'h0000_001B);
		nc <= 1;
		run(4'h0, 1);
		check(pos, 32'h0000_0004, "free fwd");
		check({31'h0, dir_out}, 32'h0000_0001, "fwd dir");
		$display("test external reference done");
		// disable goes first, so that the stop is followed by a reference run
		ahb_write(`RLSW_CFG_OFS, 32'h0000_0018);
		nc <= 0;
		ahb_write(`RLSW_CTRL_OFS, 32'h0000_0000);
		p0 = pos;
		run(4'h2, 0);
		check(pos - p0, 32'hFFFF_FFFA, "disable");
		sw_at <= -6;
		ahb_write(`RLSW_CFG_OFS, 32'h0000_0010);
		run(4'h6, 0);
		check(32'(pos inside {-4, -3}), 32'h0000_0001, "stop");
		ahb_read(`RLSW_STAT_OFS, rd);
		check({31'h0, rd[2]}, 32'h0000_0001, "lost");
		$display("test limit reactions done");
		sw_at <= 100000;
		gap_min = 1000000;
		ahb_write(`RLSW_CFG_OFS, 32'h0000_001A);
		ahb_write(`RLSW_CTRL_OFS, 32'h0000_0003);
		run(4'h0, 1);
		check(pos, 32'h0000_0001, "shaft mark");
		check(32'(gap_min >= 99 && gap_min <= 101), 32'h0000_0001, "min rate");
		ahb_read(`RLSW_STAT_OFS, rd);
		check({30'h0, rd[2], out1}, 32'h0000_0001, "ref done");
		$display("test internal reference done");
		ana_in <= 10'h005;
		repeat (2) @(posedge clock);
		// mode and start in one write, started from the register side
		ahb_write(`RLSW_CTRL_OFS, 32'h0000_0005);
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0) ahb_read(`RLSW_STAT_OFS, rd);
		rd_chk(`RLSW_POS_OFS, 32'h0000_0014);
		rd_chk(`RLSW_CTRL_OFS, 32'h0000_0001);
		$display("test analogue done");
		end_of_test();
	end
endmodule : rlsw_bench
